/* logic/ctc_defs.svh */
// Purpose: Constants of the cell TC interrupt logic
// Assumes: Register index times four gives the APB byte address
// Notes: Offsets are register indices, not byte addresses
// How it works
// - A transmit indication reaches the pin only with its enable, tx summary, port and pin enables set.
// - A receive indication reaches the pin only with its enable, rx summary, port and pin enables set.
// - Transmit enables for parity, start-of-cell, tx overflow, rx overflow and cell sent reset to 1.
// - Bit 2 of tx enable and status is factory test with enable default 1; bits 1:0 stay 0.
// - Receive enables in bits 7,6,5,3,2,1,0 reset to 1 and bit 4 is held at 0.
// - The tx indication register latches parity, start, tx overflow, rx overflow and cell sent.
// - The rx indication register latches delineation, HEC, cell, idle, screen and flow field events.
// - A single-event indication is set only on a 0 to 1 status change while enabled.
// - The delineation indication is set on both status changes while enabled.
// - Reading an indication register clears the bits that the read returned.
// - Reading the tx status register clears the flags that the read returned.
// - A parity error on a transmit data octet sets status bit 7.
// - A start-of-cell error from the ATM layer sets status bit 6.
// - Transmit FIFO overflow sets status bit 5 and receive FIFO overflow sets bit 4.
// - Only a non-idle sent cell sets status bit 3.
// - The delineation status is the present state, not a latched event.
`ifndef CTC_DEFS_SVH
`define CTC_DEFS_SVH

// ==================================================
// Register indices
`define CTC_IDX_SUMMARY 10'h001
`define CTC_IDX_PORT 10'h201
`define CTC_IDX_MODE 10'h202
`define CTC_IDX_TX_EN 10'h028
`define CTC_IDX_RX_EN 10'h029
`define CTC_IDX_TX_IND 10'h02C
`define CTC_IDX_RX_IND 10'h02D
`define CTC_IDX_TX_STAT 10'h02E

// ==================================================
// Reset values and writable bits
`define CTC_TX_EN_RST 8'hFC
`define CTC_TX_EN_MASK 8'hFC
`define CTC_RX_EN_RST 8'hEF
`define CTC_RX_EN_MASK 8'hEF
`define CTC_TX_IND_MASK 8'hF8
`define CTC_RX_IND_MASK 8'hEF
`define CTC_RX_DUAL_MASK 8'h80
`define CTC_CTRL_RST 1'b0

// ==================================================
// Field positions
`define CTC_B_PARITY 7
`define CTC_B_CELL_START 6
`define CTC_B_TX_OVER 5
`define CTC_B_RX_OVER 4
`define CTC_B_CELL_SENT 3
`define CTC_B_SUM_TX 1
`define CTC_B_SUM_RX 0
`define CTC_B_PORT_EN 0
`define CTC_B_PIN_EN 3

`endif

/* logic/ctc_edge_latch.sv */
// Purpose: Edge detection and latching of one indication register
// Assumes: Status bits come from logic on the same clock
// Notes: DUAL_MASK selects bits that latch on both edges
`timescale 1ns/10ps
module ctc_edge_latch
	import ctc_pkg::*;
#(
	parameter logic [7:0] DUAL_MASK = 8'h00
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Event bundle
	ctc_evt_if.core evt
);

	ctc_edge_state_t st_reg;
	ctc_edge_state_t st_next;
	logic [7:0] rise;
	logic [7:0] fall;
	logic [7:0] set;

	// ==================================================
	// Edge detect and latch
	always_comb
	begin
		st_next = st_reg;
		rise = evt.stat & ~st_reg.prev;
		fall = ~evt.stat & st_reg.prev & DUAL_MASK;
		set = (rise | fall) & evt.en;
		st_next.ind = (st_reg.ind & ~evt.clr) | set;
		st_next.prev = evt.stat;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign evt.ind = st_reg.ind;

	// ==================================================
	// Checks
	property p_edge_sets;
		@(posedge i_clk) disable iff (!i_rst_n)
		(set != 8'h00) |=> ((evt.ind & $past(set)) == $past(set));
	endproperty
	a_edge_sets: assert property (p_edge_sets) else $error("enabled edge not latched");

	property p_dual_fall;
		@(posedge i_clk) disable iff (!i_rst_n)
		((~evt.stat & st_reg.prev & DUAL_MASK & evt.en) != 8'h00) |=> ((evt.ind & DUAL_MASK) != 8'h00);
	endproperty
	a_dual_fall: assert property (p_dual_fall) else $error("dual falling edge lost");

	property p_clear;
		@(posedge i_clk) disable iff (!i_rst_n)
		(evt.clr != 8'h00 && set == 8'h00) |=> ((evt.ind & $past(evt.clr)) == 8'h00);
	endproperty
	a_clear: assert property (p_clear) else $error("indication not cleared");

endmodule

/* logic/ctc_evt_if.sv */
// Purpose: Status, enable and clear bundle of one indication register
// Assumes: Single clock domain
// Notes: None
`timescale 1ns/10ps
interface ctc_evt_if;
	logic [7:0] stat;
	logic [7:0] en;
	logic [7:0] clr;
	logic [7:0] ind;

	modport core (input stat, input en, input clr, output ind);
	modport user (output stat, output en, output clr, input ind);
endinterface

/* logic/ctc_int_top.sv */
// Purpose: Cell TC interrupt enables, indications and tx status with APB access
// Assumes: Event inputs come from datapath logic on i_clk
// Notes: Zero wait-state APB, read data captured in the setup cycle
`timescale 1ns/10ps
`include "ctc_defs.svh"
module ctc_int_top
	import ctc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// Transmit events, one-cycle pulses
	input wire logic i_tx_parity_err,
	input wire logic i_cell_start_err,
	input wire logic i_tx_fifo_over,
	input wire logic i_rx_fifo_over,
	input wire logic i_cell_sent,
	input wire logic i_cell_idle,
	// Receive status levels
	input wire logic i_delineation_loss,
	input wire logic i_hec_detect,
	input wire logic i_hec_correct,
	input wire logic i_cell_received,
	input wire logic i_idle_received,
	input wire logic i_screen_reject,
	input wire logic i_flow_field_nonzero,
	// Interrupt
	output logic o_host_irq_n,
	output logic o_irq
);

	ctc_top_state_t st_reg;
	ctc_top_state_t st_next;
	ctc_evt_if tx_evt ();
	ctc_evt_if rx_evt ();
	ctc_reg_id_t reg_id;
	logic setup_ph;
	logic wr_acc;
	logic rd_acc;
	logic [7:0] wbyte;
	logic [7:0] tx_set;
	logic [7:0] rx_stat;
	logic [7:0] tx_w1c;
	logic [7:0] rx_w1c;
	logic tx_live;
	logic rx_live;

	// ==================================================
	// Address decode
	function automatic ctc_reg_id_t map_reg(input logic [11:0] addr);
		ctc_reg_id_t id;
		id = CTC_REG_NONE;
		if (addr[1:0] == 2'h0)
		begin
			unique case (addr[11:2])
				`CTC_IDX_SUMMARY: id = CTC_REG_SUMMARY;
				`CTC_IDX_PORT: id = CTC_REG_PORT;
				`CTC_IDX_MODE: id = CTC_REG_MODE;
				`CTC_IDX_TX_EN: id = CTC_REG_TX_EN;
				`CTC_IDX_RX_EN: id = CTC_REG_RX_EN;
				`CTC_IDX_TX_IND: id = CTC_REG_TX_IND;
				`CTC_IDX_RX_IND: id = CTC_REG_RX_IND;
				`CTC_IDX_TX_STAT: id = CTC_REG_TX_STAT;
				default: id = CTC_REG_NONE;
			endcase
		end
		return id;
	endfunction

	assign reg_id = map_reg(i_paddr);
	assign setup_ph = i_psel & ~i_penable;
	// Unmapped writes change nothing and also raise pslverr
	assign wr_acc = i_psel & i_penable & i_pwrite & i_pstrb[0];
	assign rd_acc = i_psel & i_penable & ~i_pwrite;
	assign wbyte = i_pwdata[7:0];

	// ==================================================
	// Receive status vector
	// delineation passed as live state
	assign rx_stat = {i_delineation_loss, i_hec_detect, i_hec_correct, 1'b0,
		i_cell_received, i_idle_received, i_screen_reject, i_flow_field_nonzero};

	// ==================================================
	// Transmit status events
	always_comb
	begin
		tx_set = 8'h00;
		tx_set[`CTC_B_PARITY] = i_tx_parity_err;
		tx_set[`CTC_B_CELL_START] = i_cell_start_err;
		tx_set[`CTC_B_TX_OVER] = i_tx_fifo_over;
		tx_set[`CTC_B_RX_OVER] = i_rx_fifo_over;
		tx_set[`CTC_B_CELL_SENT] = i_cell_sent & ~i_cell_idle;
	end

	// ==================================================
	// Indication clears: read-return or write-one
	always_comb
	begin
		tx_w1c = 8'h00;
		rx_w1c = 8'h00;
		if (wr_acc && reg_id == CTC_REG_TX_IND)
			tx_w1c = wbyte;
		if (wr_acc && reg_id == CTC_REG_RX_IND)
			rx_w1c = wbyte;
	end

	assign tx_evt.stat = st_reg.tx_stat;
	assign tx_evt.en = st_reg.tx_en;
	// clear what the read returned, plus any write-one bits
	assign tx_evt.clr = ((rd_acc && reg_id == CTC_REG_TX_IND) ? st_reg.rdata : 8'h00) | tx_w1c;
	assign rx_evt.stat = rx_stat;
	assign rx_evt.en = st_reg.rx_en;
	assign rx_evt.clr = ((rd_acc && reg_id == CTC_REG_RX_IND) ? st_reg.rdata : 8'h00) | rx_w1c;

	// ==================================================
	// Indication latches
	// transmit indications
	ctc_edge_latch #(
		.DUAL_MASK(8'h00)
	) u_tx_latch (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.evt(tx_evt.core)
	);

	ctc_edge_latch #(
		.DUAL_MASK(`CTC_RX_DUAL_MASK)
	) u_rx_latch (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.evt(rx_evt.core)
	);

	// ==================================================
	// Enable gating toward the pin
	// tx and rx path gating
	assign tx_live = st_reg.sum_en[`CTC_B_SUM_TX] & (|(tx_evt.ind & st_reg.tx_en));
	assign rx_live = st_reg.sum_en[`CTC_B_SUM_RX] & (|(rx_evt.ind & st_reg.rx_en));

	// ==================================================
	// Register file and APB
	always_comb
	begin
		st_next = st_reg;
		st_next.tx_stat = (st_reg.tx_stat & ~((rd_acc && reg_id == CTC_REG_TX_STAT) ?
			st_reg.rdata : 8'h00)) | tx_set;
		if (wr_acc)
		begin
			unique case (reg_id)
				CTC_REG_SUMMARY: st_next.sum_en = wbyte[1:0];
				CTC_REG_PORT: st_next.port_en = wbyte[`CTC_B_PORT_EN];
				CTC_REG_MODE: st_next.pin_en = wbyte[`CTC_B_PIN_EN];
				// tx enables, keeps bits 1:0 at zero
				CTC_REG_TX_EN: st_next.tx_en = wbyte & `CTC_TX_EN_MASK;
				// rx enables, bit 4 held at zero
				CTC_REG_RX_EN: st_next.rx_en = wbyte & `CTC_RX_EN_MASK;
				default: st_next = st_next;
			endcase
		end
		// Capture in setup so access returns flopped data
		if (setup_ph)
		begin
			st_next.slverr = (reg_id == CTC_REG_NONE);
			unique case (reg_id)
				CTC_REG_SUMMARY: st_next.rdata = {6'h00, st_reg.sum_en};
				CTC_REG_PORT: st_next.rdata = {7'h00, st_reg.port_en};
				CTC_REG_MODE: st_next.rdata = {4'h0, st_reg.pin_en, 3'h0};
				CTC_REG_TX_EN: st_next.rdata = st_reg.tx_en;
				CTC_REG_RX_EN: st_next.rdata = st_reg.rx_en;
				// factory and reserved bits read zero
				CTC_REG_TX_IND: st_next.rdata = tx_evt.ind & `CTC_TX_IND_MASK;
				CTC_REG_RX_IND: st_next.rdata = rx_evt.ind & `CTC_RX_IND_MASK;
				CTC_REG_TX_STAT: st_next.rdata = st_reg.tx_stat;
				CTC_REG_NONE: st_next.rdata = 8'h00;
			endcase
		end
		// pin low while any fully enabled indication
		st_next.irq_n = ~(st_reg.pin_en & st_reg.port_en & (tx_live | rx_live));
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_reg <= '0;
			st_reg.tx_en <= `CTC_TX_EN_RST;
			st_reg.rx_en <= `CTC_RX_EN_RST;
			st_reg.sum_en <= {2{`CTC_CTRL_RST}};
			st_reg.port_en <= `CTC_CTRL_RST;
			st_reg.pin_en <= `CTC_CTRL_RST;
			st_reg.irq_n <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// ==================================================
	// Outputs
	assign o_pready = i_psel & i_penable;
	assign o_prdata = {24'h000000, st_reg.rdata};
	assign o_pslverr = i_psel & i_penable & st_reg.slverr;
	assign o_host_irq_n = st_reg.irq_n;
	assign o_irq = ~st_reg.irq_n;

	// ==================================================
	// Checks
	property p_tx_to_pin;
		@(posedge i_clk) disable iff (!i_rst_n)
		(tx_live && st_reg.port_en && st_reg.pin_en) |=> !o_host_irq_n;
	endproperty
	a_tx_to_pin: assert property (p_tx_to_pin) else $error("tx interrupt missing on pin");

	property p_rx_to_pin;
		@(posedge i_clk) disable iff (!i_rst_n)
		(rx_live && st_reg.port_en && st_reg.pin_en) |=> !o_host_irq_n;
	endproperty
	a_rx_to_pin: assert property (p_rx_to_pin) else $error("rx interrupt missing on pin");

	property p_pin_gate;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!st_reg.pin_en || !st_reg.port_en || (!tx_live && !rx_live)) |=> o_host_irq_n;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin low without enabled source");

	property p_tx_en_write;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_acc && reg_id == CTC_REG_TX_EN) |=> (st_reg.tx_en == ($past(wbyte) & `CTC_TX_EN_MASK));
	endproperty
	a_tx_en_write: assert property (p_tx_en_write) else $error("tx enable write wrong");

	property p_rx_en_rsvd;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_acc && reg_id == CTC_REG_RX_EN) |=> (st_reg.rx_en[4] == 1'b0);
	endproperty
	a_rx_en_rsvd: assert property (p_rx_en_rsvd) else $error("rx enable bit 4 set");

	property p_tx_rsvd;
		@(posedge i_clk) disable iff (!i_rst_n)
		(st_reg.tx_en[1:0] == 2'h0) && (st_reg.tx_stat[2:0] == 3'h0);
	endproperty
	a_tx_rsvd: assert property (p_tx_rsvd) else $error("tx reserved bit set");

	property p_stat_clear;
		@(posedge i_clk) disable iff (!i_rst_n)
		(rd_acc && reg_id == CTC_REG_TX_STAT && tx_set == 8'h00)
			|=> ((st_reg.tx_stat & $past(st_reg.rdata)) == 8'h00);
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("tx status not cleared");

	property p_parity;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_tx_parity_err |=> st_reg.tx_stat[7] ##1 tx_evt.ind[7] || !st_reg.tx_en[7]
			|| $past(st_reg.tx_stat[7], 2);
	endproperty
	a_parity: assert property (p_parity) else $error("parity error not flagged");

	property p_cell_start;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_cell_start_err |=> st_reg.tx_stat[6];
	endproperty
	a_cell_start: assert property (p_cell_start) else $error("start error not flagged");

	property p_fifo_over;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_tx_fifo_over || i_rx_fifo_over)
			|=> (st_reg.tx_stat[5] || !$past(i_tx_fifo_over))
			&& (st_reg.tx_stat[4] || !$past(i_rx_fifo_over));
	endproperty
	a_fifo_over: assert property (p_fifo_over) else $error("overflow not flagged");

	property p_idle_cell;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_cell_sent && i_cell_idle && !st_reg.tx_stat[3]) |=> !st_reg.tx_stat[3];
	endproperty
	a_idle_cell: assert property (p_idle_cell) else $error("idle cell set cell sent");

	property p_delin_live;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_delineation_loss != $past(i_delineation_loss) && st_reg.rx_en[7])
			|=> rx_evt.ind[7];
	endproperty
	a_delin_live: assert property (p_delin_live) else $error("delineation change lost");

	property p_cell_sent;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_cell_sent && !i_cell_idle) |=> st_reg.tx_stat[`CTC_B_CELL_SENT];
	endproperty
	a_cell_sent: assert property (p_cell_sent) else $error("sent cell not flagged");

	property p_tx_masked;
		@(posedge i_clk) disable iff (!i_rst_n)
		(tx_evt.stat != 8'h00)
			|=> ((tx_evt.ind & ~$past(st_reg.tx_en) & ~$past(tx_evt.ind)) == 8'h00);
	endproperty
	a_tx_masked: assert property (p_tx_masked) else $error("disabled tx source latched");

	property p_rx_masked;
		@(posedge i_clk) disable iff (!i_rst_n)
		(rx_evt.stat != 8'h00)
			|=> ((rx_evt.ind & ~$past(st_reg.rx_en) & ~$past(rx_evt.ind)) == 8'h00);
	endproperty
	a_rx_masked: assert property (p_rx_masked) else $error("disabled rx source latched");

	property p_tx_sum_off;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!st_reg.sum_en[`CTC_B_SUM_TX] && !rx_live) |=> o_host_irq_n;
	endproperty
	a_tx_sum_off: assert property (p_tx_sum_off) else $error("tx summary gate open");

	property p_rx_sum_off;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!st_reg.sum_en[`CTC_B_SUM_RX] && !tx_live) |=> o_host_irq_n;
	endproperty
	a_rx_sum_off: assert property (p_rx_sum_off) else $error("rx summary gate open");

	property p_stat_capture;
		@(posedge i_clk) disable iff (!i_rst_n)
		(setup_ph && reg_id == CTC_REG_TX_STAT) |=> (o_prdata[7:0] == $past(st_reg.tx_stat));
	endproperty
	a_stat_capture: assert property (p_stat_capture) else $error("tx status read wrong");

	property p_ind_capture;
		@(posedge i_clk) disable iff (!i_rst_n)
		(setup_ph && reg_id == CTC_REG_TX_IND)
			|=> (o_prdata[7:0] == ($past(tx_evt.ind) & `CTC_TX_IND_MASK));
	endproperty
	a_ind_capture: assert property (p_ind_capture) else $error("tx indication read wrong");

endmodule

/* logic/ctc_pkg.sv */
// Purpose: Types of the cell TC interrupt logic
// Assumes: Constants come from ctc_defs.svh
// Notes: None
package ctc_pkg;

	typedef enum logic [3:0] {
		CTC_REG_NONE = 4'b0000,
		CTC_REG_SUMMARY = 4'b0001,
		CTC_REG_PORT = 4'b0010,
		CTC_REG_MODE = 4'b0011,
		CTC_REG_TX_EN = 4'b0100,
		CTC_REG_RX_EN = 4'b0101,
		CTC_REG_TX_IND = 4'b0110,
		CTC_REG_RX_IND = 4'b0111,
		CTC_REG_TX_STAT = 4'b1000
	} ctc_reg_id_t;

	typedef struct packed {
		logic [7:0] prev;
		logic [7:0] ind;
	} ctc_edge_state_t;

	typedef struct packed {
		logic [7:0] tx_en;
		logic [7:0] rx_en;
		logic [7:0] tx_stat;
		logic [1:0] sum_en;
		logic port_en;
		logic pin_en;
		logic [7:0] rdata;
		logic slverr;
		logic irq_n;
	} ctc_top_state_t;

endpackage

/* tb/cell_tc_interrupt_logic_tb.sv */
// Purpose: Register-level tests of the cell TC interrupt logic
// Assumes: Zero wait-state APB slave, events from ctc_atm_model
// Notes: Fixed waits cover the three-edge event to pin latency
`timescale 1ns/10ps
module cell_tc_interrupt_logic_tb;
	localparam logic [11:0] A_SUM = 12'h004;
	localparam logic [11:0] A_PORT = 12'h804;
	localparam logic [11:0] A_MODE = 12'h808;
	localparam logic [11:0] A_TXE = 12'h0A0;
	localparam logic [11:0] A_RXE = 12'h0A4;
	localparam logic [11:0] A_TXI = 12'h0B0;
	localparam logic [11:0] A_RXI = 12'h0B4;
	localparam logic [11:0] A_TXS = 12'h0B8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0;
	logic [3:0] ps = 4'h0;
	logic pready, perr, irq_n, irq, qe;
	logic [31:0] prd, q;
	logic [5:0] tx_evt;
	logic [7:0] rx_lvl;
	int error_cnt = 0;
	int checked = 0;

	always #12.5 clk = ~clk;

	ctc_int_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .i_pstrb(ps), .o_pready(pready),
		.o_prdata(prd), .o_pslverr(perr), .i_tx_parity_err(tx_evt[5]),
		.i_cell_start_err(tx_evt[4]), .i_tx_fifo_over(tx_evt[3]), .i_rx_fifo_over(tx_evt[2]),
		.i_cell_sent(tx_evt[1]), .i_cell_idle(tx_evt[0]), .i_delineation_loss(rx_lvl[7]),
		.i_hec_detect(rx_lvl[6]), .i_hec_correct(rx_lvl[5]), .i_cell_received(rx_lvl[3]),
		.i_idle_received(rx_lvl[2]), .i_screen_reject(rx_lvl[1]),
		.i_flow_field_nonzero(rx_lvl[0]), .o_host_irq_n(irq_n), .o_irq(irq));
	ctc_atm_model ATM (.i_clk(clk), .o_tx_evt(tx_evt), .o_rx_lvl(rx_lvl));

	// ==================================================
	// Shared tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask

	task automatic close_out;
		if (error_cnt == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Waits for pready; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= {24'h0, d};
		ps <= s;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prd;
		qe = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00, 4'hF);
		chk(q, {24'h0, e});
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	initial
	begin
		#(25 * 6000);
		error_cnt++;
		close_out();
	end

	// ==================================================
	// Test sequence
	initial
	begin
		int i;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(A_TXE, 8'hFC);
		rd(A_RXE, 8'hEF);
		rd(A_TXI, 8'h00);
		rd(A_RXI, 8'h00);
		chk(irq_n, 1'b1);
		wr(A_TXE, 8'h00);
		rd(A_TXE, 8'h00);
		wr(A_RXE, 8'hFF);
		rd(A_RXE, 8'hEF);
		apb(1'b1, A_TXE, 8'hFC, 4'h0);
		rd(A_TXE, 8'h00);
		wr(A_TXE, 8'hFC);
		rd(A_TXE, 8'hFC);
		apb(1'b0, 12'h010, 8'h00, 4'hF);
		chk(qe, 1'b1);
		chk(q, 32'h0);
		for (i = 0; i < 5; i++)
		begin
			ATM.pulse(6'h20 >> i);
			wt(3);
			rd(A_TXS, 8'h80 >> i);
			rd(A_TXS, 8'h00);
			rd(A_TXI, 8'h80 >> i);
			rd(A_TXI, 8'h00);
		end
		ATM.pulse(6'h03);
		wt(3);
		rd(A_TXS, 8'h00);
		rd(A_TXI, 8'h00);
		ATM.pulse(6'h20);
		wt(3);
		rd(A_TXI, 8'h80);
		ATM.pulse(6'h20);
		wt(3);
		rd(A_TXI, 8'h00);
		rd(A_TXS, 8'h80);
		wr(A_TXE, 8'h00);
		ATM.pulse(6'h10);
		wt(3);
		rd(A_TXS, 8'h40);
		rd(A_TXI, 8'h00);
		wr(A_TXE, 8'hFC);
		for (i = 0; i < 8; i++)
		begin
			if (i != 4)
			begin
				ATM.set_rx(i, 1'b1);
				wt(2);
				rd(A_RXI, 8'h01 << i);
				ATM.set_rx(i, 1'b0);
				wt(2);
				rd(A_RXI, (i == 7) ? 8'h80 : 8'h00);
			end
		end
		// Transmit gating, tx summary off then on, port enable dropped and restored
		ATM.pulse(6'h08);
		wt(4);
		chk(irq_n, 1'b1);
		wr(A_SUM, 8'h01);
		wr(A_PORT, 8'h01);
		wr(A_MODE, 8'h08);
		wt(2);
		chk(irq_n, 1'b1);
		wr(A_SUM, 8'h02);
		wt(2);
		chk(irq_n, 1'b0);
		chk(irq, 1'b1);
		wr(A_PORT, 8'h00);
		wt(2);
		chk(irq_n, 1'b1);
		wr(A_PORT, 8'h01);
		wt(2);
		chk(irq_n, 1'b0);
		rd(A_TXI, 8'h20);
		wt(2);
		chk(irq_n, 1'b1);
		// Receive gating
		ATM.set_rx(6, 1'b1);
		wt(3);
		chk(irq_n, 1'b1);
		wr(A_SUM, 8'h01);
		wt(2);
		chk(irq_n, 1'b0);
		wr(A_MODE, 8'h00);
		wt(2);
		chk(irq_n, 1'b1);
		ATM.set_rx(6, 1'b0);
		rd(A_RXI, 8'h40);
		ATM.set_rx(6, 1'b1);
		wt(2);
		wr(A_RXI, 8'h40);
		rd(A_RXI, 8'h00);
		close_out();
	end
endmodule

/* tb/ctc_atm_model.sv */
// Purpose: Far-side cell layer driving transmit events and receive status
// Assumes: Driven from the bench through its tasks, same clock as the block
// Notes: Lines change only by non-blocking assignment after a rising edge
`timescale 1ns/10ps
module ctc_atm_model
(
	// Clock
	input wire logic i_clk,
	// Event lines toward the block
	output logic [5:0] o_tx_evt,
	output logic [7:0] o_rx_lvl
);
	initial
	begin
		o_tx_evt = 6'h00;
		o_rx_lvl = 8'h00;
	end

	// ==================================================
	// Transmit side
	// one-cycle event pulses
	// Bad start-of-cell only when commanded
	task automatic pulse(input logic [5:0] m);
		@(posedge i_clk);
		o_tx_evt <= m;
		@(posedge i_clk);
		o_tx_evt <= 6'h00;
	endtask

	// ==================================================
	// Receive side
	// present-state levels
	task automatic set_rx(input int b, input logic v);
		@(posedge i_clk);
		o_rx_lvl <= (o_rx_lvl & ~(8'h01 << b)) | ({7'h00, v} << b);
	endtask
endmodule
